// ==== src/rtd_defs.svh ====
// Constants for the antenna driver control block: register map, field
// positions, reset values and driver output mode codes.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef RTD_DEFS_SVH
`define RTD_DEFS_SVH

// ****************************************************************
// Register map (index as printed, byte address is four times it)
// ****************************************************************
`define RTD_IDX_DRV_MODE      8'h28
`define RTD_IDX_TX_AMP        8'h29
`define RTD_IDX_TX_CON        8'h2A
`define RTD_IDX_STATUS        8'h3F
`define RTD_ADDR_W            8
`define RTD_ADDR_LSB          2

// ****************************************************************
// Field positions
// ****************************************************************
`define RTD_DRV_TWO_INV_BIT   7
`define RTD_DRV_ONE_INV_BIT   6
`define RTD_DRV_EN_BIT        3
`define RTD_DRV_MODE_HI       2
`define RTD_DRV_MODE_LO       0
`define RTD_AMP_RED_HI        7
`define RTD_AMP_RED_LO        6
`define RTD_AMP_RES_HI        4
`define RTD_AMP_RES_LO        0
`define RTD_CON_OVS_HI        7
`define RTD_CON_OVS_LO        4
`define RTD_CON_CWMAX_BIT     3
`define RTD_CON_MINV_BIT      2
`define RTD_CON_SEL_HI        1
`define RTD_CON_SEL_LO        0

// Writable bit masks; reserved bits stay zero
`define RTD_DRV_MODE_MASK     8'hCF
`define RTD_TX_AMP_MASK       8'hDF
`define RTD_TX_CON_MASK       8'hFF

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define RTD_RESET_BYTE        8'h00
`define RTD_MODE_HIGHZ        3'h0
`define RTD_MODE_OPEN_DRAIN   3'h1
`define RTD_MODE_PUSH_PULL    3'h2
`define RTD_MODE_FIXED_LOW    3'h4
`define RTD_MODE_FIXED_HIGH   3'h5
`define RTD_SEL_NONE          2'h0
`define RTD_SEL_ENVELOPE      2'h1
`define RTD_SEL_EXTERNAL      2'h2
`define RTD_OVS_ZERO          4'h0

`endif

// ==== src/rtd_pkg.sv ====
// Types shared by the antenna driver control block.
// Assumes compilation before every module of the block.
`default_nettype none

package rtd_pkg;

  // ****************************************************************
  // Modulation sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    MOD_IDLE,
    MOD_ON,
    MOD_OVERSHOOT
  } rtd_mod_state_t;

  typedef logic [7:0] rtd_byte_t;

endpackage

`default_nettype wire

// ==== src/rtd_sync3.sv ====
// Three-stage synchroniser for a pin input.
// Assumes a level input from outside the pclk domain.
`default_nettype none

module rtd_sync3 (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and result
  input  wire logic pin_in,
  output logic      level_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Chain; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'h0;
      s2_q <= 1'h0;
      s3_q <= 1'h0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a change only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'h0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

endmodule

`default_nettype wire

// ==== src/rtd_drv.sv ====
// One antenna driver output stage: inversion, enable and output mode.
// Assumes configuration inputs already aligned to carrier clocks.
`default_nettype none
`include "rtd_defs.svh"

module rtd_drv (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Carrier and settings
  input  wire logic       wave,
  input  wire logic       invert,
  input  wire logic       enable,
  input  wire logic [2:0] mode,
  // Pin
  output logic            pin_out_q,
  output logic            pin_oe_q
);

  logic lvl;

  assign lvl = wave ^ invert;

  // Mode decode; unsupported codes park the pin at high impedance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= 1'h0;
      pin_oe_q  <= 1'h0;
    end else if (!enable) begin
      pin_out_q <= 1'h0;
      pin_oe_q  <= 1'h0;
    end else begin
      case (mode)
        `RTD_MODE_OPEN_DRAIN: begin
          pin_out_q <= 1'h0;
          pin_oe_q  <= !lvl;
        end
        `RTD_MODE_PUSH_PULL: begin
          pin_out_q <= lvl;
          pin_oe_q  <= 1'h1;
        end
        `RTD_MODE_FIXED_LOW: begin
          pin_out_q <= 1'h0;
          pin_oe_q  <= 1'h1;
        end
        `RTD_MODE_FIXED_HIGH: begin
          pin_out_q <= 1'h1;
          pin_oe_q  <= 1'h1;
        end
        default: begin
          pin_out_q <= 1'h0;
          pin_oe_q  <= 1'h0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== src/rtd_top.sv ====
// Antenna driver control: APB registers, carrier, modulation and outputs.
// Assumes a single pclk domain; the carrier is derived from pclk.
//
// How it works
// - Driver mode bit 7 inverts the wave on antenna driver two.
// - Driver mode bit 6 inverts the wave on antenna driver one.
// - Driver mode bit 3 enables both drivers together, else both are off.
// - Driver mode bits 2 to 0 pick open drain, push-pull, high impedance, fixed high or fixed low.
// - Amplitude bits 7 to 6 pick a carrier drop of 100, 250, 500 or 1000 mV below the driver supply.
// - Transmit control bit 3 forces full carrier amplitude and overrides the drop field.
// - Amplitude bits 4 to 0 set the residual carrier percentage used while modulating.
// - Transmit control bits 7 to 4 give the carrier clocks of extra modulation after each pulse.
// - Transmit control bit 2 inverts the selected modulation signal.
// - Transmit control bits 1 to 0 choose none, internal envelope or external input; 11b is reserved.
`default_nettype none
`include "rtd_defs.svh"

module rtd_top #(
  parameter int CARRIER_DIV = 4
) (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`RTD_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Modulation sources
  input  wire logic                   internal_envelope_signal,
  input  wire logic                   external_signal_input,
  // Antenna drivers
  output logic                        antenna_driver_one_out,
  output logic                        antenna_driver_one_oe,
  output logic                        antenna_driver_two_out,
  output logic                        antenna_driver_two_oe,
  // Amplitude control to the analogue stage
  output logic [1:0]                  carrier_amplitude_reduction,
  output logic                        full_amplitude,
  output logic [4:0]                  residual_carrier_level,
  output logic                        modulation_active
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int CNT_W = $clog2(CARRIER_DIV);
  localparam logic [CNT_W-1:0] DIV_LAST = CNT_W'(CARRIER_DIV - 1);
  localparam logic [CNT_W-1:0] DIV_HALF = CNT_W'(CARRIER_DIV / 2);

  rtd_pkg::rtd_byte_t drv_mode_q;
  rtd_pkg::rtd_byte_t tx_amp_q;
  rtd_pkg::rtd_byte_t tx_con_q;
  rtd_pkg::rtd_byte_t sh_drv_q;
  rtd_pkg::rtd_byte_t sh_amp_q;
  rtd_pkg::rtd_byte_t sh_con_q;
  rtd_pkg::rtd_byte_t rd_byte;
  rtd_pkg::rtd_mod_state_t mod_state_q;
  logic [CNT_W-1:0]   div_q;
  logic               tick;
  logic               phase_q;
  logic               ext_level;
  logic               mod_raw;
  logic               mod_sel;
  logic [3:0]         ovs_cnt_q;
  logic               mod_active_q;
  logic [`RTD_ADDR_W-`RTD_ADDR_LSB-1:0] idx;
  logic               hit;
  logic               wr_en;
  logic [1:0]         sel;
  logic [3:0]         ovs_len;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign idx    = paddr[`RTD_ADDR_W-1:`RTD_ADDR_LSB];
  assign hit    = (idx == `RTD_IDX_DRV_MODE) || (idx == `RTD_IDX_TX_AMP) ||
                  (idx == `RTD_IDX_TX_CON) || (idx == `RTD_IDX_STATUS);
  assign wr_en  = psel && penable && pwrite && hit;
  // Zero wait states; every access finishes in its first access cycle
  assign pready = 1'h1;

  // Software copies of the three configuration registers
  // reserved bits masked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_mode_q <= `RTD_RESET_BYTE;
      tx_amp_q   <= `RTD_RESET_BYTE;
      tx_con_q   <= `RTD_RESET_BYTE;
    end else if (wr_en) begin
      if (idx == `RTD_IDX_DRV_MODE) begin
        drv_mode_q <= pwdata[7:0] & `RTD_DRV_MODE_MASK;
      end
      if (idx == `RTD_IDX_TX_AMP) begin
        tx_amp_q <= pwdata[7:0] & `RTD_TX_AMP_MASK;
      end
      if (idx == `RTD_IDX_TX_CON) begin
        tx_con_q <= pwdata[7:0] & `RTD_TX_CON_MASK;
      end
    end
  end

  // Read mux; the status word shows live block state
  always_comb begin
    rd_byte = `RTD_RESET_BYTE;
    case (idx)
      `RTD_IDX_DRV_MODE: rd_byte = drv_mode_q;
      `RTD_IDX_TX_AMP:   rd_byte = tx_amp_q;
      `RTD_IDX_TX_CON:   rd_byte = tx_con_q;
      `RTD_IDX_STATUS:   rd_byte = {4'h0, phase_q, ext_level, (mod_state_q == rtd_pkg::MOD_OVERSHOOT),
                                    mod_active_q};
      default:           rd_byte = `RTD_RESET_BYTE;
    endcase
  end

  // Read data and error captured in the setup cycle, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'h0;
    end else if (psel && !penable) begin
      prdata  <= {24'h0, rd_byte};
      pslverr <= !hit;
    end
  end

  // ****************************************************************
  // Carrier clock
  // ****************************************************************
  assign tick = (div_q == DIV_LAST);

  // Divider; the carrier clock edge is the wrap of this counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q   <= '0;
      phase_q <= 1'h0;
    end else begin
      div_q   <= tick ? '0 : div_q + CNT_W'(1);
      phase_q <= (tick || div_q < DIV_HALF - CNT_W'(1));
    end
  end

  // Shadow copies that steer the outputs
  // settings applied at carrier clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_drv_q <= `RTD_RESET_BYTE;
      sh_amp_q <= `RTD_RESET_BYTE;
      sh_con_q <= `RTD_RESET_BYTE;
    end else if (tick) begin
      sh_drv_q <= drv_mode_q;
      sh_amp_q <= tx_amp_q;
      sh_con_q <= tx_con_q;
    end
  end

  // ****************************************************************
  // Modulation source
  // ****************************************************************
  rtd_sync3 u_ext_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (external_signal_input),
    .level_q (ext_level)
  );

  assign sel     = sh_con_q[`RTD_CON_SEL_HI:`RTD_CON_SEL_LO];
  assign ovs_len = sh_con_q[`RTD_CON_OVS_HI:`RTD_CON_OVS_LO];

  always_comb begin
    case (sel)
      `RTD_SEL_ENVELOPE: mod_raw = internal_envelope_signal;
      `RTD_SEL_EXTERNAL: mod_raw = ext_level;
      default:           mod_raw = 1'h0;
    endcase
  end

  // inversion of a selected source; no source stays unmodulated
  assign mod_sel = (sel == `RTD_SEL_ENVELOPE || sel == `RTD_SEL_EXTERNAL) ?
                   (mod_raw ^ sh_con_q[`RTD_CON_MINV_BIT]) : 1'h0;

  // ****************************************************************
  // Modulation sequencer with overshoot extension
  // ****************************************************************
  // extra carrier clocks after each pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_state_q <= rtd_pkg::MOD_IDLE;
      ovs_cnt_q   <= `RTD_OVS_ZERO;
    end else if (tick) begin
      case (mod_state_q)
        rtd_pkg::MOD_IDLE: begin
          if (mod_sel) begin
            mod_state_q <= rtd_pkg::MOD_ON;
          end
        end
        rtd_pkg::MOD_ON: begin
          if (!mod_sel && ovs_len != `RTD_OVS_ZERO) begin
            mod_state_q <= rtd_pkg::MOD_OVERSHOOT;
            ovs_cnt_q   <= ovs_len;
          end else if (!mod_sel) begin
            mod_state_q <= rtd_pkg::MOD_IDLE;
          end
        end
        rtd_pkg::MOD_OVERSHOOT: begin
          // A new pulse cuts the extension short
          if (mod_sel) begin
            mod_state_q <= rtd_pkg::MOD_ON;
            ovs_cnt_q   <= `RTD_OVS_ZERO;
          end else if (ovs_cnt_q == 4'h1) begin
            mod_state_q <= rtd_pkg::MOD_IDLE;
            ovs_cnt_q   <= `RTD_OVS_ZERO;
          end else begin
            ovs_cnt_q <= ovs_cnt_q - 4'h1;
          end
        end
        default: begin
          mod_state_q <= rtd_pkg::MOD_IDLE;
          ovs_cnt_q   <= `RTD_OVS_ZERO;
        end
      endcase
    end
  end

  assign mod_active_q = (mod_state_q != rtd_pkg::MOD_IDLE);

  // ****************************************************************
  // Amplitude control
  // ****************************************************************
  // drop code; full amplitude override; residual level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_amplitude_reduction <= 2'h0;
      full_amplitude              <= 1'h0;
      residual_carrier_level      <= 5'h00;
      modulation_active           <= 1'h0;
    end else begin
      carrier_amplitude_reduction <= sh_con_q[`RTD_CON_CWMAX_BIT] ? 2'h0 :
                                     sh_amp_q[`RTD_AMP_RED_HI:`RTD_AMP_RED_LO];
      full_amplitude              <= sh_con_q[`RTD_CON_CWMAX_BIT];
      residual_carrier_level      <= sh_amp_q[`RTD_AMP_RES_HI:`RTD_AMP_RES_LO];
      modulation_active           <= mod_active_q;
    end
  end

  // ****************************************************************
  // Driver outputs
  // ****************************************************************
  // driver one inversion; shared enable; mode
  rtd_drv u_drv_one (
    .pclk      (pclk),
    .presetn   (presetn),
    .wave      (phase_q),
    .invert    (sh_drv_q[`RTD_DRV_ONE_INV_BIT]),
    .enable    (sh_drv_q[`RTD_DRV_EN_BIT]),
    .mode      (sh_drv_q[`RTD_DRV_MODE_HI:`RTD_DRV_MODE_LO]),
    .pin_out_q (antenna_driver_one_out),
    .pin_oe_q  (antenna_driver_one_oe)
  );

  // driver two inversion; unsupported codes float
  rtd_drv u_drv_two (
    .pclk      (pclk),
    .presetn   (presetn),
    .wave      (phase_q),
    .invert    (sh_drv_q[`RTD_DRV_TWO_INV_BIT]),
    .enable    (sh_drv_q[`RTD_DRV_EN_BIT]),
    .mode      (sh_drv_q[`RTD_DRV_MODE_HI:`RTD_DRV_MODE_LO]),
    .pin_out_q (antenna_driver_two_out),
    .pin_oe_q  (antenna_driver_two_oe)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_two_invert;
    (sh_drv_q[`RTD_DRV_EN_BIT] && sh_drv_q[`RTD_DRV_MODE_HI:`RTD_DRV_MODE_LO] == `RTD_MODE_PUSH_PULL) |=>
      (antenna_driver_two_out == ($past(phase_q) ^ $past(sh_drv_q[`RTD_DRV_TWO_INV_BIT])));
  endproperty
  a_two_invert: assert property (p_two_invert)
    else $error("driver two level does not follow its invert bit");

  property p_one_invert;
    (sh_drv_q[`RTD_DRV_EN_BIT] && sh_drv_q[`RTD_DRV_MODE_HI:`RTD_DRV_MODE_LO] == `RTD_MODE_PUSH_PULL && !phase_q) |=>
      (antenna_driver_one_out == $past(sh_drv_q[`RTD_DRV_ONE_INV_BIT]));
  endproperty
  a_one_invert: assert property (p_one_invert)
    else $error("driver one level does not follow its invert bit");

  property p_enable_off;
    !sh_drv_q[`RTD_DRV_EN_BIT] |=> (!antenna_driver_one_oe && !antenna_driver_two_oe);
  endproperty
  a_enable_off: assert property (p_enable_off)
    else $error("a driver is active while disabled");

  property p_fixed_high;
    (sh_drv_q[`RTD_DRV_EN_BIT] && sh_drv_q[`RTD_DRV_MODE_HI:`RTD_DRV_MODE_LO] == `RTD_MODE_FIXED_HIGH) |=>
      (antenna_driver_one_out && antenna_driver_one_oe && antenna_driver_two_out && antenna_driver_two_oe);
  endproperty
  a_fixed_high: assert property (p_fixed_high)
    else $error("fixed high mode not driving high");

  property p_drop_code;
    !sh_con_q[`RTD_CON_CWMAX_BIT] |=> (carrier_amplitude_reduction == $past(sh_amp_q[7:6]));
  endproperty
  a_drop_code: assert property (p_drop_code)
    else $error("amplitude drop code not passed on");

  property p_full_amp;
    sh_con_q[`RTD_CON_CWMAX_BIT] |=> (full_amplitude && carrier_amplitude_reduction == 2'h0);
  endproperty
  a_full_amp: assert property (p_full_amp)
    else $error("full amplitude override not applied");

  property p_residual;
    $changed(sh_amp_q[4:0]) |=> (residual_carrier_level == $past(sh_amp_q[4:0]));
  endproperty
  a_residual: assert property (p_residual)
    else $error("residual level not passed on");

  property p_overshoot;
    (tick && mod_state_q == rtd_pkg::MOD_ON && !mod_sel && ovs_len != 4'h0) |=>
      (mod_state_q == rtd_pkg::MOD_OVERSHOOT && ovs_cnt_q == $past(ovs_len));
  endproperty
  a_overshoot: assert property (p_overshoot)
    else $error("overshoot extension not started with its length");

  property p_mod_invert;
    (sel == `RTD_SEL_ENVELOPE) |-> (mod_sel == (internal_envelope_signal ^ sh_con_q[`RTD_CON_MINV_BIT]));
  endproperty
  a_mod_invert: assert property (p_mod_invert)
    else $error("envelope modulation inversion wrong");

  property p_no_source;
    (sel == `RTD_SEL_NONE && mod_state_q == rtd_pkg::MOD_IDLE && tick) |=> !mod_active_q;
  endproperty
  a_no_source: assert property (p_no_source)
    else $error("modulation started with no source");

  property p_shadow_hold;
    !tick |=> $stable(sh_drv_q) && $stable(sh_amp_q) && $stable(sh_con_q);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold)
    else $error("drive settings changed between carrier clocks");

  property p_reserved_zero;
    1'h1 |-> ((drv_mode_q & ~`RTD_DRV_MODE_MASK) == 8'h00 && (tx_amp_q & ~`RTD_TX_AMP_MASK) == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits hold a written value");

endmodule

`default_nettype wire

// ==== verification/rtd_antenna_model.sv ====
// Antenna network model: resolves the two driver pins to line levels.
// Assumes driver outputs and enables taken straight from the block's pins.
`default_nettype none

module rtd_antenna_model (
  // Driver pins
  input  wire logic one_out,
  input  wire logic one_oe,
  input  wire logic two_out,
  input  wire logic two_oe,
  // Line levels
  output logic      one_level,
  output logic      two_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // Coil pulls a released pin up to the driver supply, so no stale level
  assign one_level = one_oe ? one_out : 1'h1;
  assign two_level = two_oe ? two_out : 1'h1;
endmodule

`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the antenna driver control block.
// Assumes the design sources and the antenna model are compiled first.
`default_nettype none
`include "rtd_defs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int         DIV   = 2;
  localparam logic [7:0] A_DRV = 8'(`RTD_IDX_DRV_MODE << 2);
  localparam logic [7:0] A_AMP = 8'(`RTD_IDX_TX_AMP << 2);
  localparam logic [7:0] A_CON = 8'(`RTD_IDX_TX_CON << 2);
  localparam logic [7:0] A_STS = 8'(`RTD_IDX_STATUS << 2);
  localparam logic [7:0] A_BAD = 8'h40;

  logic        pclk, presetn, psel, penable, pwrite, env, ext;
  logic [7:0]  paddr, amp, con, drv;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er, o1, e1, o2, e2, l1, l2, full, mact, hi, lo;
  logic [1:0]  red, iv;
  logic [4:0]  res;
  logic [2:0]  m;
  int          n_fail, checked, c0, cn, nv;
  integer      seed = 32'hE328;
  logic [7:0]  adr[3] = '{A_DRV, A_AMP, A_CON};
  logic [7:0]  wv[3]  = '{8'hF2, 8'hFF, 8'hFE};
  logic [7:0]  ev[3]  = '{8'hC2, 8'hDF, 8'hFE};
  logic [2:0]  modes[5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};

  rtd_top #(.CARRIER_DIV(DIV)) u_rtd_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_envelope_signal(env), .external_signal_input(ext),
    .antenna_driver_one_out(o1), .antenna_driver_one_oe(e1),
    .antenna_driver_two_out(o2), .antenna_driver_two_oe(e2),
    .carrier_amplitude_reduction(red), .full_amplitude(full),
    .residual_carrier_level(res), .modulation_active(mact));

  rtd_antenna_model u_rtd_antenna_model (
    .one_out(o1), .one_oe(e1), .two_out(o2), .two_oe(e2), .one_level(l1), .two_level(l2));

  // 50 MHz clock
  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t %s: saw %0h want %0h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready rather than assuming zero wait states
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    // Only the watchdog ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task settle(input int n);
    repeat (n) @(negedge pclk);
  endtask

  task set_env(input logic v);
    @(posedge pclk);
    env <= v;
  endtask

  // Cycles that modulation stays active after the envelope drops
  task meas(output int c);
    set_env(1'h0);
    c = 0;
    // Sample off the launching edge so the registered flag has settled
    @(negedge pclk);
    while (mact === 1'h1 && c < 200) begin
      @(negedge pclk);
      c++;
    end
  endtask

  function logic [1:0] exp_red(input logic [7:0] a, input logic [7:0] c);
    return c[3] ? 2'h0 : a[7:6];
  endfunction

  task test_done;
    $display("Counts: %0d checks, %0d mismatches", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    test_done;
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    {presetn, psel, penable, pwrite, env, ext} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    n_fail = 0;
    checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      apb(1'h0, adr[i], 8'h00);
      chk(rd, 32'h0, "reset value");
      apb(1'h1, adr[i], wv[i]);
      apb(1'h0, adr[i], 8'h00);
      chk({rd[30:0], er}, {23'h0, ev[i], 1'h0}, "readback");
    end
    apb(1'h1, A_BAD, 8'h55);
    chk(er, 1'h1, "unmapped write");
    apb(1'h0, A_BAD, 8'h00);
    chk({rd[30:0], er}, 32'h1, "unmapped read");
    $display("test registers done");
    // only supported mode codes are ever written
    for (int i = 0; i < 10; i++) begin
      m = modes[i % 5];
      iv = 2'($random(seed));
      apb(1'h1, A_DRV, {iv, 2'h0, 1'h1, m});
      settle(DIV + 2);
      hi = 1'h0;
      lo = 1'h0;
      repeat (4) begin
        @(negedge pclk);
        hi = hi | (l1 === 1'h1);
        lo = lo | (l1 === 1'h0);
        case (m)
          3'h0: chk({e1, e2}, 2'h0, "high-z");
          3'h1: chk({e1 & o1, e2 & o2}, 2'h0, "open drain");
          3'h2: chk({e1, e2, o1 ^ o2}, {2'h3, iv[1] ^ iv[0]}, "push-pull");
          default: chk({e1, o1, e2, o2}, {1'h1, m[0], 1'h1, m[0]}, "fixed");
        endcase
        if (m == 3'h1 || m == 3'h2) chk(l1 ^ l2, iv[1] ^ iv[0], "line levels");
      end
      if (m == 3'h1 || m == 3'h2) chk({hi, lo}, 2'h3, "carrier wave");
    end
    apb(1'h1, A_DRV, 8'h02);
    settle(DIV + 2);
    chk({e1, e2}, 2'h0, "drivers off");
    $display("test drive modes done");
    repeat (8) begin
      amp = 8'($random(seed));
      con = 8'($random(seed)) & 8'hFC;
      apb(1'h1, A_AMP, amp);
      apb(1'h1, A_CON, con);
      apb(1'h0, A_AMP, 8'h00);
      chk(rd, {24'h0, amp & 8'hDF}, "amplitude readback");
      settle(DIV + 2);
      chk(red, exp_red(amp, con), "reduction");
      chk(full, con[3], "full amplitude");
      chk(res, amp[4:0], "residual");
    end
    $display("test amplitude done");
    set_env(1'h1);
    apb(1'h1, A_CON, 8'h00);
    settle(8);
    chk(mact, 1'h0, "no source");
    apb(1'h1, A_CON, 8'h03);
    settle(8);
    chk(mact, 1'h0, "reserved source");
    apb(1'h1, A_CON, 8'h01);
    settle(8);
    chk(mact, 1'h1, "envelope source");
    apb(1'h0, A_STS, 8'h00);
    chk({rd[31:4], rd[2:0], er}, 32'h2, "status word");
    meas(c0);
    for (int k = 0; k < 3; k++) begin
      nv = (k == 0) ? 15 : ($random(seed) & 15);
      apb(1'h1, A_CON, {4'(nv), 4'h1});
      set_env(1'h1);
      settle(8);
      meas(cn);
      chk(32'(cn - c0 >= (nv - 1) * DIV && cn - c0 <= (nv + 1) * DIV), 32'h1, "overshoot");
    end
    apb(1'h1, A_CON, 8'h05);
    settle(8);
    chk(mact, 1'h1, "inverted low");
    set_env(1'h1);
    settle(8);
    chk(mact, 1'h0, "inverted high");
    apb(1'h1, A_CON, 8'h02);
    @(posedge pclk);
    ext <= 1'h1;
    settle(10);
    chk(mact, 1'h1, "external high");
    @(posedge pclk);
    ext <= 1'h0;
    settle(10);
    chk(mact, 1'h0, "external low");
    $display("test modulation done");
    test_done;
  end
endmodule

`default_nettype wire
